// File: hdl/idt_pkg.sv
// Constants, opcode patterns and decoded-word carrier for the instruction decoder.
// Assumes a single 40 MHz clock domain shared with program memory and datapath.
package idt_pkg;

    // ------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------
    localparam int          INSTR_W       = 14;
    localparam int          OSC_PER_CYCLE = 4;
    localparam logic [1:0]  PHASE_LAST    = 2'h3;
    localparam logic [1:0]  PHASE_READ    = 2'h1;
    localparam logic [1:0]  CYCLES_ZERO   = 2'h0;
    localparam logic [1:0]  CYCLES_ONE    = 2'h1;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int OPC_HI   = 13;
    localparam int OPC_LO   = 8;
    localparam int DEST_BIT = 7;
    localparam int FA_HI    = 6;
    localparam int BIT_HI   = 9;
    localparam int BIT_LO   = 7;
    localparam int LIT_HI   = 7;
    localparam int TGT_HI   = 10;
    localparam int PTR_BIT  = 2;
    localparam int MODE_HI  = 1;

    // File addresses that act as indirect access ports
    localparam logic [6:0] INDIRECT_PORT0 = 7'h00;
    localparam logic [6:0] INDIRECT_PORT1 = 7'h01;

    // ------------------------------------------------------------
    // Opcode patterns, don't-care positions as ?
    // ------------------------------------------------------------
    localparam logic [13:0] OP_CALL        = 14'b10_0???_????_????;
    localparam logic [13:0] OP_JUMP        = 14'b10_1???_????_????;
    localparam logic [13:0] OP_RETURN      = 14'b00_0000_0000_1000;
    localparam logic [13:0] OP_RET_INT     = 14'b00_0000_0000_1001;
    localparam logic [13:0] OP_CALL_W      = 14'b00_0000_0000_1010;
    localparam logic [13:0] OP_BRANCH_W    = 14'b00_0000_0000_1011;
    localparam logic [13:0] OP_RET_LIT     = 14'b11_0100_????_????;
    localparam logic [13:0] OP_REL_BRANCH  = 14'b11_001?_????_????;
    localparam logic [13:0] OP_LOAD_PAGE   = 14'b11_0001_1???_????;
    localparam logic [13:0] OP_SKIP_CLR    = 14'b01_10??_????_????;
    localparam logic [13:0] OP_SKIP_SET    = 14'b01_11??_????_????;
    localparam logic [13:0] OP_DEC_SKIP    = 14'b00_1011_????_????;
    localparam logic [13:0] OP_INC_SKIP    = 14'b00_1111_????_????;
    localparam logic [13:0] OP_PTR_STEP    = 14'b00_0000_0001_????;
    localparam logic [13:0] OP_CLEAR_W     = 14'b00_0001_0000_00??;
    localparam logic [13:0] OP_BIT_CLASS   = 14'b01_????_????_????;
    localparam logic [13:0] OP_BYTE_LOW    = 14'b00_????_????_????;
    localparam logic [13:0] OP_BYTE_HIGH   = 14'b11_01??_????_????;
    localparam logic [13:0] OP_BYTE_SUBB   = 14'b11_1011_????_????;
    localparam logic [13:0] OP_BYTE_ADDC   = 14'b11_1101_????_????;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        IDT_CLASS_BYTE    = 2'b00,
        IDT_CLASS_BIT     = 2'b01,
        IDT_CLASS_LITCTRL = 2'b10
    } idt_class_t;

    typedef enum logic [1:0] {
        IDT_STEP_PRE_INC  = 2'b00,
        IDT_STEP_PRE_DEC  = 2'b01,
        IDT_STEP_POST_INC = 2'b10,
        IDT_STEP_POST_DEC = 2'b11
    } idt_step_t;

    typedef struct packed {
        idt_class_t  iclass;
        logic [5:0]  opcode;
        logic        dest_file;
        logic [6:0]  file_addr;
        logic [2:0]  bit_num;
        logic [7:0]  literal;
        logic [10:0] target;
        logic [6:0]  page_lit;
        logic        ptr_num;
        idt_step_t   pointer_step_mode;
        logic        names_file;
        logic        indirect;
        logic        is_skip;
    } idt_dec_t;

endpackage

// File: hdl/idt_phase_gen.sv
// Oscillator phase divider: four clocks per instruction cycle.
// Assumes mclk is the oscillator clock and resetn is asynchronous active low.
`timescale 1ns/1ps
`default_nettype none
module idt_phase_gen
    import idt_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       resetn,
    output logic [1:0]      phase,
    output logic            cycle_end
);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;  // Wraps after four clocks
        end
    end

    assign cycle_end = (phase == PHASE_LAST);

endmodule
`default_nettype wire

// File: hdl/idt_decoder.sv
// Instruction decoder and execution timing sequencer.
// Assumes program memory presents the next word on instr_word, stable at each
// cycle end, and the datapath drives ptr_in_prog and skip_cond on mclk.
//
// Contract
// - Each instruction is one 14-bit word holding opcode and all operands.
// - Opcodes fall into byte, bit, and literal-and-control classes.
// - Instructions take one cycle unless listed as multi-cycle.
// - Literal call and working-register call take two cycles.
// - Plain return, return with literal, interrupt return take two cycles.
// - Jumps, branches and taken skips take two cycles.
// - Indirect access with pointer in program memory adds one cycle.
// - One instruction cycle is four oscillator clocks.
// - File-register instructions always read before writing the register.
// - Destination bit zero writes working register, one writes file; clear W asserts neither w_write nor file_write.
// - File address field selects 0x00 to 0x7F in current bank.
// - Bit field selects one bit within the 8-bit register.
// - Pointer number selects one of two pointer pairs.
// - Two-bit mode picks pre/post increment/decrement.
// - Don't-care bits never change execution.
`timescale 1ns/1ps
`default_nettype none
module idt_decoder
    import idt_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               resetn,
    input  wire logic [INSTR_W-1:0] instr_word,
    input  wire logic [1:0]         ptr_in_prog,
    input  wire logic               skip_cond,
    output idt_dec_t                dec,
    output logic                    dec_valid,
    output logic                    fetch_next,
    output logic                    file_read,
    output logic                    file_write,
    output logic                    w_write,
    output logic                    flush_cycle,
    output logic [1:0]              phase,
    output logic [1:0]              extra_left
);

    // ------------------------------------------------------------
    // Cycle phases
    // ------------------------------------------------------------
    logic cycle_end;

    idt_phase_gen u_phase (
        .mclk      (mclk),
        .resetn    (resetn),
        .phase     (phase),
        .cycle_end (cycle_end)
    );

    // ------------------------------------------------------------
    // Decoding functions
    // ------------------------------------------------------------
    function automatic idt_class_t classify(input logic [13:0] w);
        idt_class_t c;
        c = IDT_CLASS_LITCTRL;
        if (w ==? OP_BIT_CLASS) begin
            c = IDT_CLASS_BIT;
        end else if ((w ==? OP_BYTE_LOW) && (w[13:8] != 6'h00)) begin
            c = IDT_CLASS_BYTE;
        end else if ((w ==? OP_BYTE_HIGH) && !(w ==? OP_RET_LIT)) begin
            c = IDT_CLASS_BYTE;
        end else if ((w ==? OP_BYTE_SUBB) || (w ==? OP_BYTE_ADDC)) begin
            c = IDT_CLASS_BYTE;
        end else if ((w[13:8] == 6'h00) && w[7]) begin
            c = IDT_CLASS_BYTE;  // Move W to file lives in the zero page
        end
        return c;
    endfunction

    // Fixed two-cycle instructions, skips excluded since they depend on the test
    function automatic logic is_two_cycle(input logic [13:0] w);
        return (w ==? OP_CALL) || (w ==? OP_CALL_W)
            || (w ==? OP_RETURN) || (w ==? OP_RET_LIT) || (w ==? OP_RET_INT)
            || (w ==? OP_JUMP) || (w ==? OP_REL_BRANCH) || (w ==? OP_BRANCH_W);
    endfunction

    function automatic idt_dec_t decode(input logic [13:0] w);
        idt_dec_t d;
        d                   = '0;
        d.iclass            = classify(w);
        d.opcode            = w[OPC_HI:OPC_LO];
        d.file_addr         = w[FA_HI:0];
        d.dest_file         = w[DEST_BIT];
        d.bit_num           = w[BIT_HI:BIT_LO];
        d.literal           = w[LIT_HI:0];
        d.target            = w[TGT_HI:0];
        d.page_lit          = (w ==? OP_LOAD_PAGE) ? w[6:0] : 7'h00;
        d.names_file        = (d.iclass != IDT_CLASS_LITCTRL) && !(w ==? OP_CLEAR_W);
        d.is_skip           = (w ==? OP_SKIP_CLR) || (w ==? OP_SKIP_SET)
                           || (w ==? OP_DEC_SKIP) || (w ==? OP_INC_SKIP);
        if (w ==? OP_PTR_STEP) begin
            d.indirect          = 1'b1;
            d.ptr_num           = w[PTR_BIT];
            d.pointer_step_mode = idt_step_t'(w[MODE_HI:0]);
        end else if (d.names_file && ((d.file_addr == INDIRECT_PORT0)
                                   || (d.file_addr == INDIRECT_PORT1))) begin
            d.indirect = 1'b1;
            d.ptr_num  = d.file_addr[0];
        end
        // Byte ops in the first two opcode rows also take the destination from bit 7
        if ((w[13:8] == 6'h00) || (w[13:8] == 6'h01)) begin
            d.dest_file = w[DEST_BIT];
        end
        return d;
    endfunction

    // ------------------------------------------------------------
    // Next-instruction decode
    // ------------------------------------------------------------
    idt_dec_t next_dec;
    logic     next_two;

    // Don't-care bits are masked by the ?-patterns, so 0 or 1 decode alike
    assign next_dec = decode(instr_word);
    assign next_two = is_two_cycle(instr_word);

    // ------------------------------------------------------------
    // Cycle sequencing
    // ------------------------------------------------------------
    logic first_cycle;
    logic ind_penalty;
    logic skip_taken;

    // Pointer location is sampled in the first cycle, after the pointer settles
    assign ind_penalty = dec_valid && first_cycle && dec.indirect
                         && ptr_in_prog[dec.ptr_num];
    assign skip_taken  = dec_valid && first_cycle && dec.is_skip && skip_cond;
    assign fetch_next  = cycle_end && (extra_left == CYCLES_ZERO)
                         && !ind_penalty && !skip_taken;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dec       <= '0;
            dec_valid <= 1'b0;
        end else if (fetch_next) begin
            dec       <= next_dec;
            dec_valid <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            extra_left  <= CYCLES_ZERO;
            first_cycle <= 1'b0;
        end else if (cycle_end) begin
            if (fetch_next) begin
                extra_left  <= next_two ? CYCLES_ONE : CYCLES_ZERO;
                first_cycle <= 1'b1;
            end else if (first_cycle) begin
                // Both penalties may stack: up to three cycles in total
                extra_left  <= extra_left + {1'b0, skip_taken}
                               + {1'b0, ind_penalty} - CYCLES_ONE;
                first_cycle <= 1'b0;
            end else begin
                extra_left  <= extra_left - CYCLES_ONE;
            end
        end
    end

    // ------------------------------------------------------------
    // Read-modify-write strobes
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            file_read  <= 1'b0;
            file_write <= 1'b0;
            w_write    <= 1'b0;
        end else begin
            // Read always precedes write, even for write-only instructions
            file_read  <= dec_valid && first_cycle && dec.names_file
                          && (phase == PHASE_READ);
            file_write <= dec_valid && first_cycle && dec.names_file
                          && dec.dest_file && (phase == PHASE_LAST - 2'h1);
            w_write    <= dec_valid && first_cycle && dec.names_file
                          && (dec.iclass == IDT_CLASS_BYTE) && !dec.dest_file
                          && (phase == PHASE_LAST - 2'h1);
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            flush_cycle <= 1'b0;
        end else if (cycle_end) begin
            flush_cycle <= !fetch_next;  // Extra cycles execute as no-ops
        end
    end

endmodule
`default_nettype wire

// File: testbench/idt_decoder_assertions.sv
// Checker for decoder timing and decode relations.
// Assumes it is bound to idt_decoder and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module idt_decoder_assertions
    import idt_pkg::*;
(
    input wire logic               mclk,
    input wire logic               resetn,
    input wire logic [INSTR_W-1:0] instr_word,
    input wire logic [1:0]         ptr_in_prog,
    input wire logic               skip_cond,
    input wire idt_dec_t           dec,
    input wire logic               dec_valid,
    input wire logic               fetch_next,
    input wire logic               file_read,
    input wire logic               file_write,
    input wire logic               w_write,
    input wire logic               flush_cycle,
    input wire logic [1:0]         phase,
    input wire logic [1:0]         extra_left
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Word taken at fetch, compared against decode one edge later
    logic [13:0] last_word;
    always_ff @(posedge mclk) begin
        last_word <= instr_word;
    end
    property p_fetch_phase;
        fetch_next |-> phase == PHASE_LAST;
    endproperty
    a_fetch_phase: assert property (p_fetch_phase) else $error("fetch off phase 3");
    property p_phase_step;
        1'b1 |=> phase == $past(phase) + 2'h1;
    endproperty
    a_phase_step: assert property (p_phase_step) else $error("phase not stepping");
    property p_single;
        fetch_next && instr_word[13:8] == 6'h07 && instr_word[6:1] != 6'h00 |-> ##4 fetch_next;
    endproperty
    a_single: assert property (p_single) else $error("plain op not one cycle");
    property p_two;
        fetch_next && (instr_word[13:12] == 2'b10 || instr_word[13:8] == 6'h34
            || instr_word inside {14'h0008, 14'h0009}) |-> ##4 !fetch_next ##4 fetch_next;
    endproperty
    a_two: assert property (p_two) else $error("call or return not two cycles");
    property p_owed;
        extra_left != CYCLES_ZERO |-> !fetch_next;
    endproperty
    a_owed: assert property (p_owed) else $error("fetch while cycles owed");
    property p_rmw;
        file_write |-> $past(file_read);
    endproperty
    a_rmw: assert property (p_rmw) else $error("write without prior read");
    property p_dest;
        file_write || w_write |-> dec.dest_file == file_write;
    endproperty
    a_dest: assert property (p_dest) else $error("result routed wrongly");
    property p_byte_fields;
        fetch_next && instr_word[13:12] == 2'b00 |=>
            dec.opcode == last_word[13:8] && dec.file_addr == last_word[6:0];
    endproperty
    a_byte_fields: assert property (p_byte_fields) else $error("byte fields wrong");
    property p_bit;
        fetch_next && instr_word[13:12] == 2'b01 |=>
            dec.iclass == IDT_CLASS_BIT && dec.bit_num == last_word[9:7];
    endproperty
    a_bit: assert property (p_bit) else $error("bit fields wrong");
    c_owed: cover property (fetch_next ##4 extra_left != CYCLES_ZERO);
    c_wwrite: cover property (w_write);
    c_flush: cover property (flush_cycle);
endmodule
bind idt_decoder idt_decoder_assertions u_chk (.mclk(mclk), .resetn(resetn),
    .instr_word(instr_word), .ptr_in_prog(ptr_in_prog), .skip_cond(skip_cond),
    .dec(dec), .dec_valid(dec_valid), .fetch_next(fetch_next), .file_read(file_read),
    .file_write(file_write), .w_write(w_write), .flush_cycle(flush_cycle),
    .phase(phase), .extra_left(extra_left));
`default_nettype wire

// File: testbench/idt_prog_mem.sv
// Program memory model: one 14-bit word per fetch.
// Assumes fetch_next marks the edge at which the decoder takes the word.
`timescale 1ns/1ps
`default_nettype none
module idt_prog_mem (
    input  wire logic   mclk,
    input  wire logic   resetn,
    input  wire logic   fetch_next,
    output logic [13:0] instr_word
);
    logic [13:0] mem [0:15];
    logic [3:0]  pc;
    // Sequential only; branches are not redirected, timing is all we judge
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pc <= 4'h0;
        end else if (fetch_next) begin
            pc <= pc + 4'h1;
        end
    end
    assign instr_word = mem[pc];
endmodule
`default_nettype wire

// File: testbench/idt_decoder_tb.sv
// Self-checking bench for the instruction decoder.
// Assumes package, decoder, memory model and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module idt_decoder_tb;
    import idt_pkg::*;
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic [13:0] instr_word;
    logic [1:0]  ptr_in_prog = 2'h0;
    logic        skip_cond = 1'b0;
    idt_dec_t    dec, d1;
    logic        dec_valid, fetch_next, file_read, file_write, w_write, flush_cycle;
    logic [1:0]  phase, extra_left;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          n_rd, n_wf, n_ww, n_fl;
    always #12.5 mclk = ~mclk;
    idt_decoder u_dut (.mclk(mclk), .resetn(resetn), .instr_word(instr_word),
        .ptr_in_prog(ptr_in_prog), .skip_cond(skip_cond), .dec(dec), .dec_valid(dec_valid),
        .fetch_next(fetch_next), .file_read(file_read), .file_write(file_write),
        .w_write(w_write), .flush_cycle(flush_cycle), .phase(phase), .extra_left(extra_left));
    idt_prog_mem u_mem (.mclk(mclk), .resetn(resetn), .fetch_next(fetch_next),
        .instr_word(instr_word));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            end_sim();
        end
    end
    // Clocks to the next fetch; strobes counted, first decode kept
    task automatic next_fetch(output int n);
        n = 0;
        n_rd = 0;
        n_wf = 0;
        n_ww = 0;
        n_fl = 0;
        do begin
            @(negedge mclk);
            n++;
            if (n == 1) d1 = dec;
            n_rd += file_read;
            n_wf += file_write;
            n_ww += w_write;
            n_fl += flush_cycle;
        end while (fetch_next !== 1'b1 && n < 40);
    endtask
    task automatic gap(input int cycles);
        int n;
        next_fetch(n);
        check(n, 4 * cycles);
        check(n_fl, 4 * (cycles - 1));
        check(dec_valid, 1'b1);
    endtask
    task automatic run(input logic [13:0] w0, w1, w2, input logic [1:0] ptr, input logic sk);
        int n;
        @(posedge mclk);
        #2;
        resetn = 1'b0;
        ptr_in_prog = ptr;
        skip_cond = sk;
        for (int i = 0; i < 16; i++) u_mem.mem[i] = 14'h0000;
        u_mem.mem[0] = w0;
        u_mem.mem[1] = w1;
        u_mem.mem[2] = w2;
        repeat (2) @(posedge mclk);
        #2;
        resetn = 1'b1;
        next_fetch(n);
        check(n, OSC_PER_CYCLE);
        check(dec_valid, 1'b0);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_byte;
        run(14'h07A0, 14'h077F, 14'h00FF, 2'h0, 1'b0);
        gap(1);
        check(d1.opcode, 6'h07);
        check(n_wf, 1);
        check(n_rd, 1);
        gap(1);
        check(d1.file_addr, 7'h7F);
        check(n_ww, 1);
        gap(1);
        check(n_rd, 1);
    endtask
    task automatic t_two;
        logic [13:0] w [8] = '{14'h27FF, 14'h2A55, 14'h0008, 14'h0009,
                               14'h000A, 14'h000B, 14'h3412, 14'h3255};
        foreach (w[i]) begin
            run(w[i], 14'h0000, 14'h0000, 2'h0, 1'b0);
            gap(2);
            check(d1.iclass, IDT_CLASS_LITCTRL);
            if (i == 1) check(d1.target, 11'h255);
            if (i == 6) check(d1.literal, 8'h12);
        end
    endtask
    task automatic t_skip;
        logic [13:0] w [4] = '{14'h1FA5, 14'h1BA5, 14'h0BA5, 14'h0FA5};
        for (int s = 0; s < 2; s++) begin
            foreach (w[i]) begin
                run(w[i], 14'h0000, 14'h0000, 2'h0, s[0]);
                gap(1 + s);
                if (i < 2) check(d1.bit_num, 3'h7);
            end
        end
    endtask
    task automatic t_indirect;
        run(14'h0781, 14'h0780, 14'h0000, 2'h2, 1'b0);
        gap(2);
        gap(1);
        for (int k = 0; k < 8; k++) begin
            run(14'h0010 | 14'(k), 14'h0000, 14'h0000, 2'h2, 1'b0);
            gap(1 + k[2]);
            check(d1.ptr_num, k[2]);
            check(d1.pointer_step_mode, k[1:0]);
        end
    endtask
    task automatic t_dontcare;
        // Clear W names no file, so neither form fires a strobe
        run(14'h0100, 14'h0103, 14'h31FF, 2'h0, 1'b0);
        gap(1);
        check(n_ww, 0);
        check(n_rd, 0);
        gap(1);
        check(n_ww, 0);
        check(n_rd, 0);
        check(d1.iclass, IDT_CLASS_BYTE);
        gap(1);
        check(d1.page_lit, 7'h7F);
        // Literal op beside byte ops in the top group must not touch the file
        run(14'h3E55, 14'h3B55, 14'h0000, 2'h0, 1'b0);
        gap(1);
        check(d1.iclass, IDT_CLASS_LITCTRL);
        check(n_rd, 0);
        gap(1);
        check(d1.iclass, IDT_CLASS_BYTE);
        check(n_ww, 1);
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        t_byte();
        t_two();
        t_skip();
        t_indirect();
        t_dontcare();
        end_sim();
    end
endmodule
`default_nettype wire
